// File: design/i2cee_regs.vh
// Contract
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - sda stable while scl high
// - ignore traffic until a start
// - address top nibble must be 1010
// - select bits match pins or address
// - last address bit: 1 read, 0 write
// - ack matching address on ninth clock
// - ack word address and write data
// - read: shift byte, release ninth clock
// - byte write; program starts at stop
// - busy programming: released, no response
// - page write up to sixteen bytes
// - increment only low four address bits
// - past sixteen bytes wrap within page
// - poll: nack while busy, ack after
// - protect input high blocks all writes
// - sample protect before first data byte
// - array starts erased to FF
// - read address: send current byte at once
// - nack plus stop returns to idle
// - sample on scl rise, drive on fall
// - read pointer wraps at memory end
`ifndef I2CEE_REGS_VH
`define I2CEE_REGS_VH
`define I2CEE_DEV_CODE   4'hA
`define I2CEE_CMP_MASK   3'h6
`define I2CEE_ERASED     8'hFF
`define I2CEE_MEM_DEPTH  512
`define I2CEE_PAGE_SIZE  16
`define I2CEE_PIN_RST    6'h03
`define I2CEE_CLK_NS     8
`define I2CEE_TPROG_NS   5000000
`define I2CEE_TPROG_CYC  (`I2CEE_TPROG_NS / `I2CEE_CLK_NS)
`define I2CEE_FIFO_W     12
`define I2CEE_FIFO_D     8
`endif

// File: design/i2cee_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "i2cee_regs.vh"

module i2cee_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clock,
  input  wire             rst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW:0]      wrPtr_q;
  reg [AW:0]      rdPtr_q;
  wire            full;
  wire            empty;

  // extra pointer bit separates full from empty
  assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty    = (wrPtr_q == rdPtr_q);
  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = store[rdPtr_q[AW-1:0]];

  // pointer and storage update
  always @(posedge clock) begin
    if (rst) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full) begin
        store[wrPtr_q[AW-1:0]] <= inData;
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty)
        rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule // i2cee_fifo

module i2cee_slave #(
  parameter PROG_CYCLES = `I2CEE_TPROG_CYC
) (
  input  wire       clock,
  input  wire       rst,
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOe,
  input  wire [2:0] chipSelectPin,
  input  wire       writeProtect,
  output reg        busy
);
  // protocol states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DEV  = 3'h1;
  localparam [2:0] S_WADR = 3'h2;
  localparam [2:0] S_WDAT = 3'h3;
  localparam [2:0] S_ACK  = 3'h4;
  localparam [2:0] S_RDAT = 3'h5;
  localparam [2:0] S_MACK = 3'h6;
  localparam [2:0] S_WAIT = 3'h7;
  // program states
  localparam [1:0] P_IDLE  = 2'h0;
  localparam [1:0] P_DRAIN = 2'h1;
  localparam [1:0] P_WRITE = 2'h2;
  localparam [1:0] P_WAIT  = 2'h3;
  // pin levels forced in reset: both bus lines idle high, the other pins low
  localparam [5:0] PIN_RST = `I2CEE_PIN_RST;

  reg  [7:0]  mem [0:`I2CEE_MEM_DEPTH-1];
  reg  [7:0]  pageBuf [0:`I2CEE_PAGE_SIZE-1];
  reg  [15:0] dirty_q;
  reg  [5:0]  sync1_q;
  reg  [5:0]  sync2_q;
  reg  [5:0]  sync3_q;
  reg  [5:0]  pin_q;
  reg  [5:0]  pinPrev_q;
  reg  [2:0]  state_q;
  reg  [2:0]  next_q;
  reg  [3:0]  bitCnt_q;
  reg  [7:0]  rxShift_q;
  reg  [7:0]  txShift_q;
  reg  [8:0]  ptr_q;
  reg  [4:0]  page_q;
  reg         firstData_q;
  reg         reject_q;
  reg         wrote_q;
  reg         push_q;
  reg  [11:0] pushData_q;
  reg         clrDirty_q;
  reg         commitReq_q;
  reg  [1:0]  prog_q;
  reg  [3:0]  progIdx_q;
  reg  [19:0] progCnt_q;
  wire [5:0]  pinRaw;
  wire        scl;
  wire        sda;
  wire        sclRise;
  wire        sclFall;
  wire        startSeen;
  wire        stopSeen;
  wire        fifoInReady;
  wire [11:0] fifoOut;
  wire        fifoOutValid;
  wire        drainReady;
  wire [7:0]  rdByte;
  integer     k;

  // address byte decode: fixed code plus pin compare on masked bits
  function addrMatch;
    input [7:0] dev;
    input [2:0] pins;
    begin
      addrMatch = (dev[7:4] == `I2CEE_DEV_CODE) &&
                  (((dev[3:1] ^ pins) & `I2CEE_CMP_MASK) == 3'h0);
    end
  endfunction

  // erased delivery state
  initial begin
    for (k = 0; k < `I2CEE_MEM_DEPTH; k = k + 1)
      mem[k] = `I2CEE_ERASED;
  end

  assign pinRaw = {writeProtect, chipSelectPin, sdaIn, sclIn};

  // three-stage synchroniser, level taken when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gSync
      always @(posedge clock) begin
        if (rst) begin
          sync1_q[g] <= PIN_RST[g];
          sync2_q[g] <= PIN_RST[g];
          sync3_q[g] <= PIN_RST[g];
          pin_q[g]   <= PIN_RST[g];
        end else begin
          sync1_q[g] <= pinRaw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g])
            pin_q[g] <= sync3_q[g];
        end
      end
    end
  endgenerate

  // edge and condition detection
  always @(posedge clock) begin
    if (rst)
      pinPrev_q <= `I2CEE_PIN_RST;
    else
      pinPrev_q <= pin_q;
  end

  assign scl       = pin_q[0];
  assign sda       = pin_q[1];
  assign sclRise   = scl & ~pinPrev_q[0];
  assign sclFall   = ~scl & pinPrev_q[0];
  assign startSeen = scl & pinPrev_q[0] & pinPrev_q[1] & ~sda;
  assign stopSeen  = scl & pinPrev_q[0] & ~pinPrev_q[1] & sda;
  assign rdByte    = mem[ptr_q];

  // bus protocol engine
  always @(posedge clock) begin
    if (rst) begin
      state_q     <= S_IDLE;
      next_q      <= S_IDLE;
      bitCnt_q    <= 4'h0;
      rxShift_q   <= 8'h00;
      txShift_q   <= 8'hFF;
      ptr_q       <= 9'h000;
      page_q      <= 5'h00;
      firstData_q <= 1'b0;
      reject_q    <= 1'b0;
      wrote_q     <= 1'b0;
      push_q      <= 1'b0;
      pushData_q  <= 12'h000;
      clrDirty_q  <= 1'b0;
      commitReq_q <= 1'b0;
      sdaOe       <= 1'b0;
      sdaOut      <= 1'b0;
    end else begin
      push_q      <= 1'b0;
      clrDirty_q  <= 1'b0;
      commitReq_q <= 1'b0;
      if (startSeen) begin
        state_q  <= S_DEV;
        bitCnt_q <= 4'h0;
        sdaOe    <= 1'b0;
      end else if (stopSeen) begin
        state_q <= S_IDLE;
        sdaOe   <= 1'b0;
        if (wrote_q && !reject_q)
          commitReq_q <= 1'b1;
        wrote_q <= 1'b0;
      end else begin
        case (state_q)
          S_DEV, S_WADR, S_WDAT: begin
            if (sclRise && bitCnt_q != 4'h8) begin
              rxShift_q <= {rxShift_q[6:0], sda};
              bitCnt_q  <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              if (state_q == S_DEV) begin
                if (addrMatch(rxShift_q, pin_q[4:2]) && !busy && !commitReq_q) begin
                  sdaOe   <= 1'b1;
                  state_q <= S_ACK;
                  if (rxShift_q[0]) begin
                    next_q <= S_RDAT;
                  end else begin
                    next_q     <= S_WADR;
                    reject_q   <= 1'b0;
                    wrote_q    <= 1'b0;
                    clrDirty_q <= 1'b1;
                    if ((~`I2CEE_CMP_MASK & 3'h1) != 3'h0)
                      ptr_q[8] <= rxShift_q[1];
                  end
                end else begin
                  state_q <= S_WAIT;
                end
              end else if (state_q == S_WADR) begin
                sdaOe       <= 1'b1;
                ptr_q[7:0]  <= rxShift_q;
                page_q      <= {ptr_q[8], rxShift_q[7:4]};
                firstData_q <= 1'b1;
                next_q      <= S_WDAT;
                state_q     <= S_ACK;
              end else if (reject_q || !fifoInReady) begin
                state_q <= S_WAIT;
              end else begin
                sdaOe      <= 1'b1;
                push_q     <= 1'b1;
                pushData_q <= {ptr_q[3:0], rxShift_q};
                ptr_q[3:0] <= ptr_q[3:0] + 4'h1;
                wrote_q    <= 1'b1;
                next_q     <= S_WDAT;
                state_q    <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (sclFall) begin
              bitCnt_q <= 4'h0;
              state_q  <= next_q;
              if (firstData_q) begin
                reject_q    <= pin_q[5];
                firstData_q <= 1'b0;
              end
              if (next_q == S_RDAT) begin
                txShift_q <= rdByte;
                sdaOe     <= ~rdByte[7];
                ptr_q     <= ptr_q + 9'h001;
                bitCnt_q  <= 4'h1;
              end else begin
                sdaOe <= 1'b0;
              end
            end
          end
          S_RDAT: begin
            if (sclFall) begin
              if (bitCnt_q == 4'h8) begin
                sdaOe   <= 1'b0;
                state_q <= S_MACK;
              end else begin
                txShift_q <= {txShift_q[6:0], 1'b1};
                sdaOe     <= ~txShift_q[6];
                bitCnt_q  <= bitCnt_q + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (sclRise) begin
              if (!sda) begin
                next_q  <= S_RDAT;
                state_q <= S_ACK;
              end else begin
                state_q <= S_WAIT;
              end
            end
          end
          S_IDLE, S_WAIT: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state_q <= S_IDLE;
            sdaOe   <= 1'b0;
          end
        endcase
      end
    end
  end

  i2cee_fifo #(
    .WIDTH (`I2CEE_FIFO_W),
    .DEPTH (`I2CEE_FIFO_D),
    .AW    (3)
  ) uFifo (
    .clock    (clock),
    .rst      (rst),
    .inData   (pushData_q),
    .inValid  (push_q),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (drainReady)
  );

  // buffer drain stalls while the array is being programmed
  assign drainReady = (prog_q != P_WRITE);

  // page buffer fill, later bytes of a wrapped page overwrite earlier ones
  always @(posedge clock) begin
    if (rst) begin
      dirty_q <= 16'h0000;
    end else if (clrDirty_q) begin
      dirty_q <= 16'h0000;
    end else if (fifoOutValid && drainReady) begin
      pageBuf[fifoOut[11:8]] <= fifoOut[7:0];
      dirty_q[fifoOut[11:8]] <= 1'b1;
    end
  end

  // internal program cycle
  always @(posedge clock) begin
    if (rst) begin
      prog_q    <= P_IDLE;
      progIdx_q <= 4'h0;
      progCnt_q <= 20'h00000;
      busy      <= 1'b0;
    end else begin
      case (prog_q)
        P_IDLE: begin
          if (commitReq_q) begin
            prog_q <= P_DRAIN;
            busy   <= 1'b1;
          end
        end
        P_DRAIN: begin
          if (!fifoOutValid && !push_q) begin
            prog_q    <= P_WRITE;
            progIdx_q <= 4'h0;
          end
        end
        P_WRITE: begin
          if (dirty_q[progIdx_q])
            mem[{page_q, progIdx_q}] <= pageBuf[progIdx_q];
          progIdx_q <= progIdx_q + 4'h1;
          if (progIdx_q == 4'hF) begin
            prog_q    <= P_WAIT;
            progCnt_q <= 20'h00000;
          end
        end
        P_WAIT: begin
          progCnt_q <= progCnt_q + 20'h00001;
          if (progCnt_q >= PROG_CYCLES[19:0] - 20'h00001) begin
            prog_q <= P_IDLE;
            busy   <= 1'b0;
          end
        end
        default: begin
          prog_q <= P_IDLE;
          busy   <= 1'b0;
        end
      endcase
    end
  end
endmodule // i2cee_slave
`default_nettype wire

// File: tb/i2cee_checker.sv
`timescale 1ns/1ps
`default_nettype none
module i2cee_checker #(
  parameter PROG_CYCLES = 50
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [2:0] chipSelectPin,
  input wire logic       writeProtect,
  input wire logic       busy
);
  int busyCnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // length of the current program wait
  always @(posedge clock) begin
    if (rst || !busy) busyCnt_q <= 0;
    else busyCnt_q <= busyCnt_q + 1;
  end
  // relations at the target ports
  reset_idle_a: assert property (disable iff (1'b0) rst |=> !sdaOe && !busy)
    else $error("not idle after reset");
  drive_low_a: assert property (!sdaOut)
    else $error("data drive value not low");
  busy_quiet_a: assert property (busy |-> !sdaOe)
    else $error("line driven while programming");
  scl_high_a: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("data moved while clock high");
  ack_hold_a: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("drive dropped too early");
  busy_len_a: assert property ($fell(busy) |->
    busyCnt_q >= PROG_CYCLES + 17 && busyCnt_q <= PROG_CYCLES + 26)
    else $error("program wait length wrong");
  busy_idle_a: assert property ($rose(busy) |-> sclIn && sdaIn)
    else $error("program started off a stop");
  wp_block_a: assert property (writeProtect |-> !$rose(busy))
    else $error("program while protected");
  stop_idle_a: assert property (sclIn && $rose(sdaIn) |=> !sdaOe [*8])
    else $error("drive after stop");
endmodule // i2cee_checker
`default_nettype wire

// File: tb/i2cee_master.sv
`timescale 1ns/1ps
`default_nettype none
module i2cee_master #(
  parameter int H = 12
) (
  input wire logic clock,
  input wire logic busLvl,
  output var logic scl,
  output var logic sda
);
  // bus idles released, both lines high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // data falls while clock high
  task automatic start();
    sda = 1'b1;
    scl = 1'b1;
    tick(H);
    sda = 1'b0;
    tick(H);
  endtask
  // data rises while clock high
  task automatic stop();
    scl = 1'b0;
    tick(H);
    sda = 1'b0;
    tick(H);
    scl = 1'b1;
    tick(H);
    sda = 1'b1;
    tick(H);
  endtask
  // one clock pulse, data moves only while clock low
  task automatic bitIo(input logic b, output logic r);
    scl = 1'b0;
    tick(H / 2);
    sda = b;
    tick(H / 2);
    scl = 1'b1;
    tick(H / 2);
    r = busLvl;
    tick(H / 2);
  endtask
  // byte msb first, then the ninth clock; ackIn high ends a read
  task automatic byteIo(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                        output logic ack);
    for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
    bitIo(ackIn, ack);
  endtask
endmodule // i2cee_master
`default_nettype wire

// File: tb/test_i2cee_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cee_regs.vh"
module test_i2cee_slave;
  localparam int PROG = 300;
  logic       clock;
  logic       rst;
  logic       writeProtect;
  logic [2:0] chipSelectPin;
  logic       scl;
  logic       sdaM;
  logic       sdaOut;
  logic       sdaOe;
  logic       busy;
  wire        busLvl;
  int         err_total;
  int         n_tests;
  int         mem[512];
  int         ptr;
  logic [7:0] seed;
  logic [7:0] q;
  logic       ack;
  // open-drain wire with pull-up, low if either side pulls
  assign busLvl = sdaM & ~sdaOe;
  i2cee_slave #(.PROG_CYCLES(PROG)) uut (.clock(clock), .rst(rst), .sclIn(scl),
    .sdaIn(busLvl), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectPin(chipSelectPin),
    .writeProtect(writeProtect), .busy(busy));
  i2cee_master m (.clock(clock), .busLvl(busLvl), .scl(scl), .sda(sdaM));
  // compare and count
  task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // target address byte from the pin levels
  function automatic logic [7:0] dev(input logic a8, input logic rw);
    return {`I2CEE_DEV_CODE, chipSelectPin[2:1], a8, rw};
  endfunction
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // cut a hang; the run needs about 14000 clocks
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    writeProtect = 1'b0;
    chipSelectPin = 3'h5;
    seed = 8'h44;
    err_total = 0;
    n_tests = 0;
    foreach (mem[i]) mem[i] = `I2CEE_ERASED;
    m.tick(2);
    rst = 1'b0;
    m.tick(8);
    // a byte with no start is ignored
    m.byteIo(dev(1'b0, 1'b0), 1'b1, q, ack);
    check("no start ack", ack, 1'b1);
    m.stop();
    // wrong code, then pin mismatch
    m.start();
    m.byteIo({4'hB, dev(1'b0, 1'b0)} >> 4, 1'b1, q, ack);
    check("code ack", ack, 1'b1);
    m.start();
    m.byteIo(dev(1'b0, 1'b0) ^ 8'h08, 1'b1, q, ack);
    check("pin ack", ack, 1'b1);
    // page write of 31 bytes from offset 1 of the top page
    m.start();
    m.byteIo(dev(1'b1, 1'b0), 1'b1, q, ack);
    check("address ack", ack, 1'b0);
    m.byteIo(8'hF1, 1'b1, q, ack);
    check("word ack", ack, 1'b0);
    for (int i = 0; i < 31; i++) begin
      seed = lfsr(seed);
      mem[9'h1F0 + (1 + i) % 16] = seed;
      m.byteIo(seed, 1'b1, q, ack);
      check("data ack", ack, 1'b0);
    end
    m.stop();
    check("busy", busy, 1'b1);
    // poll until the program wait ends
    for (int i = 0; i < 20; i++) begin
      m.start();
      m.byteIo(dev(1'b1, 1'b0), 1'b1, q, ack);
      if (i == 0) check("poll busy ack", ack, 1'b1);
      if (ack === 1'b0) break;
    end
    check("poll ack", ack, 1'b0);
    m.stop();
    // immediate read across the page and the memory end
    ptr = 9'h1F0;
    m.start();
    m.byteIo(dev(1'b0, 1'b1), 1'b1, q, ack);
    check("read ack", ack, 1'b0);
    for (int i = 0; i < 18; i++) begin
      m.byteIo(8'hFF, i == 17, q, ack);
      check("read data", q, 9'(mem[ptr]));
      ptr = (ptr + 1) % 512;
    end
    m.stop();
    // protected write is refused at the first data byte
    writeProtect = 1'b1;
    m.start();
    m.byteIo(dev(1'b0, 1'b0), 1'b1, q, ack);
    check("wp address ack", ack, 1'b0);
    m.byteIo(8'h10, 1'b1, q, ack);
    check("wp word ack", ack, 1'b0);
    m.byteIo(8'h5A, 1'b1, q, ack);
    check("wp data ack", ack, 1'b1);
    m.stop();
    m.tick(40);
    check("wp busy", busy, 1'b0);
    writeProtect = 1'b0;
    m.tick(20);
    end_of_test();
  end
endmodule // test_i2cee_slave
bind i2cee_slave i2cee_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (.clock(clock), .rst(rst),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .chipSelectPin(chipSelectPin), .writeProtect(writeProtect), .busy(busy));
`default_nettype wire
